// [hw/pbch_ctl.sv]
`timescale 1ns/1ps

// Functional notes
// - As target, assert DEVSEL to claim cycle
// - As initiator, master abort without DEVSEL
// - Initiator drives FRAME from transaction start
// - FRAME deasserted marks the final data phase
// - Assert REQ when initiator ownership needed
// - Arbiter GNT hands ownership; parking handled
// - Configuration access only with IDSEL asserted
// - IRDY initiator ready, TRDY target ready
// - Phase completes when IRDY and TRDY sampled
// - Wait states while not both asserted
// - PERR only when parity response enabled
// - SERR pulse only when system error enabled
// - CardBus address parity error also pulses SERR
// - STOP from target ends the transaction
// - Initiator drives even parity one clock later
// - Target compares parity, data mismatch raises PERR
module pbch_ctl
#(
	parameter int LEN_W = pbch_pkg::PBCH_LEN_W,
	parameter int DEVSEL_LIMIT = pbch_pkg::PBCH_DEVSEL_LIMIT
)
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Bus control pins
	input wire pbch_pkg::pbch_ctl_t pin_in,
	output pbch_pkg::pbch_ctl_t pin_out,
	output pbch_pkg::pbch_ctl_t pin_oe,
	input wire logic gnt_n,
	input wire logic idsel,
	output logic req_n,
	output logic serr_n_out,
	output logic serr_oe,
	// Address/data path
	input wire logic [31:0] ad_in,
	input wire logic [3:0] cbe_in,
	input wire logic par_in,
	output logic ad_oe,
	output logic addr_phase,
	output logic par_out,
	output logic par_oe,
	// Command register contents
	input wire logic [15:0] cfg_command,
	// Initiator user side
	input wire logic mst_start,
	input wire logic [3:0] mst_cmd,
	input wire logic [LEN_W-1:0] mst_len,
	input wire logic mst_rdy,
	output logic mst_busy,
	output logic mst_beat,
	output logic mst_done,
	output logic mst_abort,
	output logic mst_disc,
	// Target user side
	input wire logic tgt_hit,
	input wire logic tgt_rdy,
	input wire logic tgt_disc,
	output logic tgt_sel,
	output logic tgt_beat,
	output pbch_pkg::pbch_tgt_info_t tgt_info,
	// Error events
	input wire logic sys_err,
	input wire logic cb_addr_perr,
	output logic perr_seen
);

	import pbch_pkg::*;

	localparam int TMO_W = $clog2(DEVSEL_LIMIT + 1);

	// Refuse sizes the logic cannot serve
	generate
		if (LEN_W < 1 || DEVSEL_LIMIT < 1)
		begin : g_bad_param
			$error("pbch_ctl: LEN_W and DEVSEL_LIMIT must be at least 1");
		end
	endgenerate

	typedef enum logic [1:0] {M_IDLE, M_ADDR, M_DATA, M_TURN} pbch_mst_t;
	typedef enum logic [1:0] {T_IDLE, T_DATA, T_TURN} pbch_tgt_t;

	pbch_mst_t mst_state_reg, mst_state_next;
	pbch_tgt_t tgt_state_reg, tgt_state_next;
	logic frame_reg, frame_next, irdy_reg, irdy_next;
	logic pend_reg, pend_next;
	logic [3:0] cmd_reg;
	logic [LEN_W-1:0] left_reg, left_next;
	logic [TMO_W-1:0] tmo_reg, tmo_next;
	logic dev_seen_reg, abt_reg;
	logic mst_beat_reg, mst_done_reg, mst_abort_reg, mst_disc_reg;
	logic devsel_reg, devsel_next, trdy_reg, trdy_next;
	logic stop_reg, stop_next, tfirst_reg, idle_prev_reg;
	pbch_tgt_info_t tgt_info_reg;
	logic tgt_beat_reg;
	logic chk_data_reg, chk_addr_reg;
	logic perr_reg, perr_next, perr_oe_reg, perr_seen_reg;
	logic serr_reg, serr_pend_reg;

	// Sampled pin levels, true when asserted
	logic frame_s, irdy_s, trdy_s, devsel_s, stop_s, gnt_s, bus_idle;
	assign frame_s = ~pin_in.frame;
	assign irdy_s = ~pin_in.irdy;
	assign trdy_s = ~pin_in.trdy;
	assign devsel_s = ~pin_in.devsel;
	assign stop_s = ~pin_in.stop;
	assign gnt_s = ~gnt_n;
	assign bus_idle = ~frame_s & ~irdy_s;

	// Command register enables
	logic perr_en, serr_en;
	assign perr_en = cfg_command[PBCH_CMD_PERR_EN_BIT];
	assign serr_en = cfg_command[PBCH_CMD_SERR_EN_BIT];

	// Initiator decode
	logic m_idle, m_data, accept, mst_go, park, m_beat, m_tmo, m_end;
	logic [LEN_W-1:0] m_rem;
	assign m_idle = (mst_state_reg == M_IDLE);
	assign m_data = (mst_state_reg == M_DATA);
	assign accept = mst_start & ~pend_reg & m_idle;
	assign mst_go = m_idle & pend_reg & gnt_s & bus_idle
		& (tgt_state_reg == T_IDLE);
	assign park = m_idle & ~pend_reg & gnt_s & bus_idle
		& (tgt_state_reg == T_IDLE);
	assign m_beat = m_data & irdy_reg & trdy_s;
	assign m_rem = m_beat ? left_reg - 1'b1 : left_reg;
	assign m_tmo = m_data & ~dev_seen_reg & ~devsel_s
		& (tmo_reg >= TMO_W'(DEVSEL_LIMIT));
	assign m_end = m_data & ~frame_reg
		& (m_beat | stop_s | abt_reg | m_tmo);
	assign pend_next = accept | (pend_reg & ~mst_go);
	assign left_next = accept ? mst_len : m_rem;

	// Initiator sequence: address, data phases, turnaround
	always_comb
	begin
		mst_state_next = mst_state_reg;
		frame_next = frame_reg;
		irdy_next = irdy_reg;
		unique case (mst_state_reg)
			M_IDLE:
			begin
				if (mst_go)
				begin
					mst_state_next = M_ADDR;
					frame_next = 1'b1;
				end
			end
			M_ADDR:
			begin
				mst_state_next = M_DATA;
				frame_next = (left_reg > LEN_W'(1));
				irdy_next = mst_rdy | ~frame_next;
			end
			M_DATA:
			begin
				if (m_end)
				begin
					mst_state_next = M_TURN;
					frame_next = 1'b0;
					irdy_next = 1'b0;
				end
				else
				begin
					frame_next = frame_reg & ~stop_s & ~m_tmo
						& (m_rem > LEN_W'(1));
					irdy_next = (irdy_reg & ~m_beat) | mst_rdy
						| ~frame_next;
				end
			end
			M_TURN:
			begin
				mst_state_next = M_IDLE;
			end
		endcase
	end

	// Initiator timeout count
	always_comb
	begin
		tmo_next = tmo_reg;
		if (mst_state_reg == M_ADDR)
			tmo_next = TMO_W'(1);
		else if (m_data && tmo_reg < TMO_W'(DEVSEL_LIMIT))
			tmo_next = tmo_reg + 1'b1;
	end

	// Initiator state registers
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			mst_state_reg <= M_IDLE;
			frame_reg <= 1'b0;
			irdy_reg <= 1'b0;
			pend_reg <= 1'b0;
			cmd_reg <= 4'h0;
			left_reg <= '0;
			tmo_reg <= '0;
			dev_seen_reg <= 1'b0;
			abt_reg <= 1'b0;
		end
		else
		begin
			mst_state_reg <= mst_state_next;
			frame_reg <= frame_next;
			irdy_reg <= irdy_next;
			pend_reg <= pend_next;
			cmd_reg <= accept ? mst_cmd : cmd_reg;
			left_reg <= left_next;
			tmo_reg <= tmo_next;
			dev_seen_reg <= (mst_state_reg == M_ADDR) ? 1'b0
				: dev_seen_reg | (m_data & devsel_s);
			abt_reg <= (mst_state_reg == M_ADDR) ? 1'b0 : abt_reg | m_tmo;
		end
	end

	// Initiator user events
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			mst_beat_reg <= 1'b0;
			mst_done_reg <= 1'b0;
			mst_abort_reg <= 1'b0;
			mst_disc_reg <= 1'b0;
		end
		else
		begin
			mst_beat_reg <= m_beat;
			mst_done_reg <= m_end;
			mst_abort_reg <= m_end & (abt_reg | m_tmo);
			mst_disc_reg <= m_end & stop_s & ~abt_reg & ~m_tmo;
		end
	end

	// Target decode at the address phase
	logic t_idle, t_data, t_addr, is_cfg, cfg_sel, t_claim, t_beat, t_end;
	assign t_idle = (tgt_state_reg == T_IDLE);
	assign t_data = (tgt_state_reg == T_DATA);
	assign t_addr = t_idle & frame_s & idle_prev_reg
		& (mst_state_reg != M_ADDR);
	assign is_cfg = (cbe_in == PBCH_CMD_CFG_RD) | (cbe_in == PBCH_CMD_CFG_WR);
	assign cfg_sel = idsel & (ad_in[1:0] == PBCH_CFG_TYPE0);
	assign t_claim = t_addr & (is_cfg ? cfg_sel : tgt_hit);
	assign t_beat = t_data & irdy_s & trdy_reg;
	assign t_end = t_data & ~frame_s & irdy_s
		& (trdy_reg | stop_reg);

	// Target sequence and its driven levels
	always_comb
	begin
		tgt_state_next = tgt_state_reg;
		devsel_next = 1'b0;
		trdy_next = 1'b0;
		stop_next = 1'b0;
		unique case (tgt_state_reg)
			T_IDLE:
			begin
				if (t_claim)
				begin
					tgt_state_next = T_DATA;
					devsel_next = 1'b1;
				end
			end
			T_DATA:
			begin
				if (t_end)
					tgt_state_next = T_TURN;
				devsel_next = ~t_end;
				trdy_next = ~t_end
					& ((trdy_reg & ~t_beat) | tgt_rdy);
				stop_next = ~t_end & (stop_reg | tgt_disc);
			end
			T_TURN:
			begin
				tgt_state_next = T_IDLE;
			end
		endcase
	end

	// Target state registers
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			tgt_state_reg <= T_IDLE;
			devsel_reg <= 1'b0;
			trdy_reg <= 1'b0;
			stop_reg <= 1'b0;
			tfirst_reg <= 1'b0;
			idle_prev_reg <= 1'b1;
			tgt_info_reg <= '0;
			tgt_beat_reg <= 1'b0;
		end
		else
		begin
			tgt_state_reg <= tgt_state_next;
			devsel_reg <= devsel_next;
			trdy_reg <= trdy_next;
			stop_reg <= stop_next;
			tfirst_reg <= t_claim;
			idle_prev_reg <= bus_idle;
			tgt_info_reg <= t_claim
				? '{cmd: cbe_in, cfg: is_cfg,
					write: cbe_in[PBCH_CMD_DIR_BIT]}
				: tgt_info_reg;
			tgt_beat_reg <= t_beat;
		end
	end

	// Error detection: parity one clock after each checked phase
	logic mism, data_perr, addr_perr, serr_evt, serr_fire;
	assign data_perr = chk_data_reg & mism;
	assign addr_perr = chk_addr_reg & mism;
	assign perr_next = perr_en & data_perr;
	assign serr_evt = serr_en & (sys_err | cb_addr_perr
		| (addr_perr & perr_en));
	assign serr_fire = (serr_evt | serr_pend_reg) & ~serr_reg;

	// Error registers
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			chk_data_reg <= 1'b0;
			chk_addr_reg <= 1'b0;
			perr_reg <= 1'b0;
			perr_oe_reg <= 1'b0;
			perr_seen_reg <= 1'b0;
			serr_reg <= 1'b0;
			serr_pend_reg <= 1'b0;
		end
		else
		begin
			chk_data_reg <= (t_beat & tgt_info_reg.write)
				| (m_beat & ~cmd_reg[PBCH_CMD_DIR_BIT]);
			chk_addr_reg <= t_claim;
			perr_reg <= perr_next;
			perr_oe_reg <= perr_next | perr_reg;
			perr_seen_reg <= data_perr | addr_perr;
			serr_reg <= serr_fire;
			serr_pend_reg <= (serr_pend_reg | serr_evt) & ~serr_fire;
		end
	end

	// Parity generation and checking
	logic drive_ad;
	assign drive_ad = park | (mst_state_reg == M_ADDR)
		| (m_data & cmd_reg[PBCH_CMD_DIR_BIT])
		| (t_data & ~tgt_info_reg.write & ~tfirst_reg);

	pbch_parity u_parity
	(
		.clk(clk),
		.rst(rst),
		.ad(ad_in),
		.cbe(cbe_in),
		.par_in(par_in),
		.drive_en(drive_ad),
		.par_out(par_out),
		.par_oe(par_oe),
		.mismatch(mism)
	);

	// Pin drive, low on the wire when asserted
	logic m_drive, t_drive;
	assign m_drive = ~m_idle;
	assign t_drive = ~t_idle;
	assign pin_out = '{frame: ~frame_reg, irdy: ~irdy_reg,
		trdy: ~trdy_reg, devsel: ~devsel_reg, stop: ~stop_reg,
		perr: ~perr_reg};
	assign pin_oe = '{frame: m_drive, irdy: m_drive, trdy: t_drive,
		devsel: t_drive, stop: t_drive, perr: perr_oe_reg};
	assign req_n = ~pend_reg;
	assign serr_n_out = ~serr_reg;
	assign serr_oe = serr_reg;
	assign ad_oe = drive_ad;
	assign addr_phase = (mst_state_reg == M_ADDR);

	// User side outputs
	assign mst_busy = pend_reg | ~m_idle;
	assign mst_beat = mst_beat_reg;
	assign mst_done = mst_done_reg;
	assign mst_abort = mst_abort_reg;
	assign mst_disc = mst_disc_reg;
	assign tgt_sel = t_data;
	assign tgt_beat = tgt_beat_reg;
	assign tgt_info = tgt_info_reg;
	assign perr_seen = perr_seen_reg;

endmodule

// [hw/pbch_parity.sv]
`timescale 1ns/1ps

// Even parity over address/data and command/byte-enable lines
module pbch_parity
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Bus values as seen on the wire
	input wire logic [31:0] ad,
	input wire logic [3:0] cbe,
	input wire logic par_in,
	// Set while this device drives the address/data lines
	input wire logic drive_en,
	// Parity pin drive and check result
	output logic par_out,
	output logic par_oe,
	output logic mismatch
);

	logic par_calc_reg;
	logic par_oe_reg;

	// Parity of each phase is held for one clock, then driven or compared
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			par_calc_reg <= 1'b0;
			par_oe_reg <= 1'b0;
		end
		else
		begin
			par_calc_reg <= ^{ad, cbe};
			par_oe_reg <= drive_en;
		end
	end

	// Outputs and comparison against the parity seen on the wire
	assign par_out = par_calc_reg;
	assign par_oe = par_oe_reg;
	assign mismatch = par_calc_reg ^ par_in;

endmodule

// [shared/pbch_pkg.sv]
package pbch_pkg;

	// Bus control pin group, one bit per pin, active low on the wire
	typedef struct packed {
		logic frame;
		logic irdy;
		logic trdy;
		logic devsel;
		logic stop;
		logic perr;
	} pbch_ctl_t;

	// What the target side learned in the address phase
	typedef struct packed {
		logic [3:0] cmd;
		logic cfg;
		logic write;
	} pbch_tgt_info_t;

	// Bus commands and address phase fields
	localparam logic [3:0] PBCH_CMD_CFG_RD = 4'ha;
	localparam logic [3:0] PBCH_CMD_CFG_WR = 4'hb;
	localparam int PBCH_CMD_DIR_BIT = 0;
	localparam logic [1:0] PBCH_CFG_TYPE0 = 2'h0;

	// Command register bit positions (configuration offset 04h)
	localparam logic [7:0] PBCH_CMD_REG_OFFSET = 8'h04;
	localparam int PBCH_CMD_PERR_EN_BIT = 6;
	localparam int PBCH_CMD_SERR_EN_BIT = 8;

	// Defaults for sizes and timing counts
	localparam int PBCH_LEN_W = 8;
	localparam int PBCH_DEVSEL_LIMIT = 5;

endpackage

// [testbench/pbch_checker.sv]
`timescale 1ns/1ps
// Port-level properties of the bus control block
module pbch_checker
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Bus pins
	input wire pbch_pkg::pbch_ctl_t pin_in,
	input wire pbch_pkg::pbch_ctl_t pin_out,
	input wire pbch_pkg::pbch_ctl_t pin_oe,
	input wire logic gnt_n,
	input wire logic idsel,
	input wire logic req_n,
	input wire logic serr_n_out,
	input wire logic serr_oe,
	input wire logic [31:0] ad_in,
	input wire logic [3:0] cbe_in,
	input wire logic [15:0] cfg_command,
	// User sides and events
	input wire logic mst_start,
	input wire logic mst_busy,
	input wire logic mst_abort,
	input wire logic tgt_sel,
	input wire logic tgt_beat,
	input wire logic sys_err,
	input wire logic cb_addr_perr
);
	import pbch_pkg::*;
	default clocking @(posedge clk);
	endclocking
	default disable iff (rst);
	// Configuration command seen on the wire
	wire cfg_cmd = cbe_in == PBCH_CMD_CFG_RD || cbe_in == PBCH_CMD_CFG_WR;
	// Another initiator opens a type 0 configuration cycle
	sequence s_cfg_addr;
		$fell(pin_in.frame) && !pin_oe.frame && cfg_cmd && ad_in[1:0] == 2'h0;
	endsequence
	// Own cycle opens and no target claims it for five edges
	sequence s_no_claim;
		$rose(pin_oe.frame) ##1 pin_in.devsel [*5];
	endsequence
	a_cfg_claim: assert property (
		s_cfg_addr ##0 idsel |=> pin_oe.devsel && !pin_out.devsel)
		else $error("config cycle not claimed");
	a_cfg_skip: assert property (
		s_cfg_addr ##0 !idsel |=> !pin_oe.devsel)
		else $error("config cycle claimed without select");
	a_abort_bound: assert property (
		s_no_claim |-> ##[1:3] mst_abort)
		else $error("no abort after unclaimed cycle");
	a_req_start: assert property (
		mst_start && !mst_busy |=> !req_n)
		else $error("request not raised");
	a_frame_gnt: assert property (
		$rose(pin_oe.frame) |-> !$past(gnt_n))
		else $error("frame driven without grant");
	a_stop_end: assert property (
		mst_busy && !pin_in.stop && pin_oe.frame && !pin_out.frame |=> pin_out.frame)
		else $error("frame held after stop");
	a_data_beat: assert property (
		tgt_sel && !pin_in.irdy && !pin_in.trdy |=> tgt_beat)
		else $error("target beat missing");
	a_perr_gate: assert property (
		pin_oe.perr && !pin_out.perr |-> cfg_command[6])
		else $error("parity error driven while disabled");
	a_serr_event: assert property (
		(sys_err || cb_addr_perr) && cfg_command[8] |-> ##[1:2] serr_oe && !serr_n_out)
		else $error("system error pulse missing");
endmodule

bind pbch_ctl pbch_checker u_chk (.clk, .rst, .pin_in, .pin_out, .pin_oe,
	.gnt_n, .idsel, .req_n, .serr_n_out, .serr_oe, .ad_in, .cbe_in,
	.cfg_command, .mst_start, .mst_busy, .mst_abort, .tgt_sel, .tgt_beat,
	.sys_err, .cb_addr_perr);

// [testbench/pbch_ctl_bench.sv]
`timescale 1ns/1ps
// Self-checking bench for the bus control block
module pbch_ctl_bench;
	import pbch_pkg::*;
	logic clk = 0;
	logic rst = 1;
	wire pbch_ctl_t pin_in;
	pbch_ctl_t pin_out, pin_oe;
	pbch_tgt_info_t tgt_info;
	logic gnt_n, req_n, serr_n_out, serr_oe, par_out, par_oe, bpar;
	logic mst_busy, mst_beat, mst_done, mst_abort, mst_disc;
	logic tgt_sel, tgt_beat, perr_seen, dv, tr, sp;
	logic idsel = 0, start = 0, sys_err = 0, cb_addr_perr = 0;
	logic bf = 1, bi = 1, flip = 0;
	logic [1:0] mode = 0;
	logic [3:0] cbe = 0;
	logic [7:0] len = 0;
	logic [31:0] ad = 0;
	logic [15:0] cfg_command = 16'h0040;
	int num_errors = 0;
	int samples_checked = 0;
	// Rows: mode, length, beats, abort and disconnect flags
	logic [15:0] rows [5] = '{16'h0110, 16'h0330, 16'h1220, 16'h2202, 16'h3201};
	// Released control lines float high on their pull-ups
	function automatic logic pu(input logic oe, input logic v);
		return oe ? v : 1'b1;
	endfunction
	assign pin_in.frame = pu(pin_oe.frame, pin_out.frame) & bf;
	assign pin_in.irdy = pu(pin_oe.irdy, pin_out.irdy) & bi;
	assign pin_in.trdy = pu(pin_oe.trdy, pin_out.trdy) & tr;
	assign pin_in.devsel = pu(pin_oe.devsel, pin_out.devsel) & dv;
	assign pin_in.stop = pu(pin_oe.stop, pin_out.stop) & sp;
	assign pin_in.perr = pu(pin_oe.perr, pin_out.perr);
	// Far initiator parity trails the wire by one clock
	always @(posedge clk)
		bpar <= #5 ^{ad, cbe} ^ flip;
	pbch_ctl uut (.clk, .rst, .pin_in, .pin_out, .pin_oe, .gnt_n, .idsel,
		.req_n, .serr_n_out, .serr_oe, .ad_in(ad), .cbe_in(cbe),
		.par_in(par_oe ? par_out : bpar), .ad_oe(), .addr_phase(), .par_out,
		.par_oe, .cfg_command, .mst_start(start), .mst_cmd(cbe), .mst_len(len),
		.mst_rdy(1'b1), .mst_busy, .mst_beat, .mst_done, .mst_abort, .mst_disc,
		.tgt_hit(1'b0), .tgt_rdy(1'b1), .tgt_disc(1'b0), .tgt_sel, .tgt_beat,
		.tgt_info, .sys_err, .cb_addr_perr, .perr_seen);
	pbch_far_end far (.clk, .rst, .frame_n(pin_in.frame), .irdy_n(pin_in.irdy),
		.req_n, .en(pin_oe.frame), .mode, .gnt_n, .devsel_n(dv), .trdy_n(tr),
		.stop_n(sp));
	// Clock, 50 ns period
	initial
	begin
		forever #25 clk = ~clk;
	end
	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#5;
	endtask
	task automatic chk(input logic [7:0] s, input logic [7:0] e);
		samples_checked++;
		if (s !== e)
		begin
			num_errors++;
			$display("ERROR %0t: got %h want %h", $time, s, e);
		end
	endtask
	task automatic results();
		$display("checked %0d errors %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// One initiator transfer against the far end
	task automatic mt(input logic [15:0] r);
		logic [7:0] nb = 0;
		logic [2:0] f = 0;
		int k = 0;
		mode = r[13:12];
		len = {4'h0, r[11:8]};
		cbe = 4'h7;
		start = 1;
		step(1);
		start = 0;
		chk(req_n, 0);
		while (mst_busy === 1'b1 && k < 40)
		begin
			nb = nb + mst_beat;
			f = f | {mst_done, mst_abort, mst_disc};
			if (par_oe === 1'b1)
				chk(par_out, ^{ad, cbe});
			step(1);
			k++;
		end
		chk(nb, r[7:4]);
		chk(f, {1'b1, r[1:0]});
	endtask
	// One single-phase cycle from a far initiator
	task automatic tt(input logic [3:0] c, input logic s, input logic [1:0] a,
		input logic bp, input logic e);
		cbe = c;
		idsel = s;
		ad = {30'h0, a};
		bf = 0;
		step(1);
		bf = 1;
		bi = 0;
		cbe = 0;
		idsel = 0;
		ad = 0;
		chk(pin_oe.devsel & ~pin_out.devsel, e);
		step(1);
		flip = bp;
		step(1);
		flip = 0;
		bi = 1;
		chk(tgt_beat, e);
		if (e)
			chk(tgt_info, {c, 1'b1, c[0]});
		step(1);
		chk(pin_oe.perr & ~pin_out.perr, bp & cfg_command[6]);
		chk(perr_seen, bp);
		step(2);
	endtask
	// Main sequence
	initial
	begin
		step(6);
		chk(pin_oe, 0);
		chk({req_n, serr_oe, mst_busy}, 3'h4);
		rst = 0;
		foreach (rows[i])
			mt(rows[i]);
		tt(4'hb, 1, 0, 0, 1);
		tt(4'ha, 1, 0, 0, 1);
		tt(4'hb, 0, 0, 0, 0);
		tt(4'hb, 1, 1, 0, 0);
		tt(4'hb, 1, 0, 1, 1);
		cfg_command = 16'h0000;
		tt(4'hb, 1, 0, 1, 1);
		for (int i = 0; i < 4; i++)
		begin
			cfg_command[8] = i[1];
			sys_err = ~i[0];
			cb_addr_perr = i[0];
			step(1);
			sys_err = 0;
			cb_addr_perr = 0;
			chk(serr_oe & ~serr_n_out, i[1]);
			step(1);
			chk(serr_oe, 0);
		end
		results();
	end
	// Watchdog
	initial
	begin
		#50000;
		num_errors++;
		results();
	end
endmodule

// [testbench/pbch_far_end.sv]
`timescale 1ns/1ps
// Far end: arbiter with parking and one plain target
module pbch_far_end
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Wire levels and behaviour
	input wire logic frame_n,
	input wire logic irdy_n,
	input wire logic req_n,
	input wire logic en,
	input wire logic [1:0] mode,
	// Levels driven, high when released
	output logic gnt_n,
	output logic devsel_n,
	output logic trdy_n,
	output logic stop_n
);
	logic act_reg;
	logic last;
	logic [1:0] wait_reg;
	// Grant on request; odd modes park the bus on the device
	always_ff @(posedge clk)
		gnt_n <= rst | (req_n & ~mode[0]);
	// Final phase completes with frame high, irdy asserted and trdy or stop asserted
	assign last = act_reg && frame_n && !irdy_n && !(trdy_n && stop_n);
	// Claim, wait, then answer ready or stop until the end
	always_ff @(posedge clk)
		if (rst || last)
		begin
			act_reg <= 1'b0;
			devsel_n <= 1'b1;
			trdy_n <= 1'b1;
			stop_n <= 1'b1;
			wait_reg <= 2'h0;
		end
		else if (!act_reg)
		begin
			act_reg <= !frame_n && en && mode != 2'h2;
			devsel_n <= frame_n || !en || mode == 2'h2;
			wait_reg <= {mode == 2'h1, 1'b0};
		end
		else
		begin
			trdy_n <= wait_reg != 2'h0 || mode == 2'h3;
			stop_n <= mode != 2'h3;
			wait_reg <= wait_reg - {1'b0, wait_reg != 2'h0};
		end
endmodule
